// ### logic/msi_top.v
// Motor speed indicator and speed command select, top level.
// Assumes synchronous inputs, register port master, external open-drain pad.
//
// What this block does
// - Indicator pin shows tacho or run status
// - Coefficient is multiply value divided by divide value
// - Pulses per revolution equal pole pairs times coefficient
// - Closed loop tracks speed; open loop per flag
// - Flag clear: status low in open/closed
// - Flag set: status low only closed loop
// - At most one speed command source at once; the unused source code selects none and commands zero
// - PWM and analog inputs may be inverted
// - Serial slave at programmable address, under 400 kHz
// - Track normal or sleep top state
// - Direction high UVW, low UWV order
// - Serial source ignores speed pin entirely
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "msi_regs.vh"

module msi_top #(
    parameter W = 8
) (
    input wire clk,
    input wire nrst,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire elec_evt,
    input wire [1:0] ctl_state,
    input wire dir_in,
    input wire [W-1:0] pwm_duty,
    input wire [W-1:0] analog_duty,
    input wire [6:0] serial_addr_in,
    input wire serial_addr_valid,
    output wire serial_addr_match,
    output wire indicator_pin_o,
    output wire indicator_pin_oe,
    output wire tacho_pulse_out,
    output reg [2:0] phase_order_ff,
    output wire [W-1:0] speed_cmd,
    output reg sleep_ff
);

    // ****************************************
    // Configuration register
    // ****************************************
    reg [16:0] cfg_ff; // Configuration word
    reg [W-1:0] serial_cmd_ff; // Speed written by serial or port
    reg [W-1:0] tacho_cnt_ff; // Tacho pulse counter readback
    reg ind_ff; // Registered indicator level
    wire pulse;
    wire rd_sel = cfg_ff[`MSI_CFG_RD_SEL];
    wire flag = cfg_ff[`MSI_CFG_FLAG];
    wire [1:0] mul_sel = cfg_ff[`MSI_CFG_MUL_HI:`MSI_CFG_MUL_LO];
    wire [1:0] div_sel = cfg_ff[`MSI_CFG_DIV_HI:`MSI_CFG_DIV_LO];
    reg [2:0] den_k;
    reg nxt_ind;

    // Register writes; sleep follows its control bit
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_ff <= `MSI_CFG_RESET;
            serial_cmd_ff <= {W{1'b0}};
        end else if (reg_wr) begin
            if (reg_addr == `MSI_ADDR_CFG) begin
                cfg_ff <= reg_wdata[16:0];
            end else if (reg_addr == `MSI_ADDR_CMD) begin
                serial_cmd_ff <= reg_wdata[W-1:0];
            end
        end
    end

    // Read data in the cycle after the read strobe; unmapped reads zero
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            if (reg_addr == `MSI_ADDR_CFG) begin
                reg_rdata <= {15'h0000, cfg_ff};
            end else if (reg_addr == `MSI_ADDR_CMD) begin
                reg_rdata <= {{(32-W){1'b0}}, serial_cmd_ff};
            end else if (reg_addr == `MSI_ADDR_STAT) begin
                reg_rdata <= {27'h0000000, ind_ff, sleep_ff, ctl_state, pulse};
            end else if (reg_addr == `MSI_ADDR_SPEED) begin
                reg_rdata <= {{(32-W){1'b0}}, tacho_cnt_ff};
            end else begin
                reg_rdata <= 32'h00000000;
            end
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    // ****************************************
    // Top-level state
    // ****************************************
    // Normal or sleep, set by software
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sleep_ff <= 1'b0;
        end else begin
            sleep_ff <= cfg_ff[`MSI_CFG_SLEEP];
        end
    end

    // ****************************************
    // Serial address compare
    // ****************************************
    // Bus timing is the master's concern: SCL must stay under the limit
    assign serial_addr_match = serial_addr_valid &
        (serial_addr_in == cfg_ff[`MSI_CFG_ADDR_HI:`MSI_CFG_ADDR_LO]);

    // ****************************************
    // Tacho generation
    // ****************************************
    // Divider code to denominator
    always @* begin
        case (div_sel)
            2'h0: den_k = `MSI_DEN_1;
            2'h1: den_k = `MSI_DEN_3;
            2'h2: den_k = `MSI_DEN_4;
            default: den_k = `MSI_DEN_5;
        endcase
    end

    // One event per electrical cycle gives pole pairs times k per revolution
    msi_pulse_gen u_pulse (
        .clk(clk),
        .nrst(nrst),
        .elec_evt(elec_evt & ~sleep_ff),
        .mul_k({1'b0, mul_sel} + 3'h1),
        .den_k(den_k),
        .pulse_ff(pulse)
    );
    assign tacho_pulse_out = pulse;

    // Counter of tacho pulses for readback
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tacho_cnt_ff <= {W{1'b0}};
        end else if (pulse) begin
            tacho_cnt_ff <= tacho_cnt_ff + {{(W-1){1'b0}}, 1'b1};
        end
    end

    // ****************************************
    // Indicator level
    // ****************************************
    always @* begin
        if (rd_sel) begin
            if (flag) begin
                nxt_ind = (ctl_state != `MSI_CTL_CLOSED);
            end else begin
                nxt_ind = (ctl_state != `MSI_CTL_CLOSED) &&
                          (ctl_state != `MSI_CTL_OPEN);
            end
        end else if (ctl_state == `MSI_CTL_OPEN) begin
            nxt_ind = flag ? 1'b1 : pulse;
        end else begin
            nxt_ind = pulse;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ind_ff <= 1'b1;
        end else begin
            ind_ff <= nxt_ind;
        end
    end

    // Open drain: pull low when level is zero, release for high
    assign indicator_pin_o = 1'b0;
    assign indicator_pin_oe = ~ind_ff;

    // ****************************************
    // Phase order
    // ****************************************
    // One-hot U,V,W: bit0 U, bit1 V, bit2 W; reset starts at U
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_order_ff <= 3'h1;
        end else if (elec_evt & ~sleep_ff) begin
            if (dir_in) begin
                phase_order_ff <= {phase_order_ff[1:0], phase_order_ff[2]};
            end else begin
                phase_order_ff <= {phase_order_ff[0], phase_order_ff[2:1]};
            end
        end
    end

    // ****************************************
    // Speed command
    // ****************************************
    msi_cmd_select #(.W(W)) u_cmd (
        .clk(clk),
        .nrst(nrst),
        .src(cfg_ff[`MSI_CFG_SRC_HI:`MSI_CFG_SRC_LO]),
        .invert(cfg_ff[`MSI_CFG_INV]),
        .pwm_duty(pwm_duty),
        .analog_duty(analog_duty),
        .serial_cmd(serial_cmd_ff),
        .cmd_ff(speed_cmd)
    );

endmodule // msi_top
`default_nettype wire

// ### logic/msi_regs.vh
// Constants of the motor speed indicator and speed command select block.
// Assumes inclusion by bare name; definitions only.
`ifndef MSI_REGS_VH
`define MSI_REGS_VH

// ****************************************
// Register offsets (8-bit word addresses)
// ****************************************
`define MSI_ADDR_CFG 8'h00
`define MSI_ADDR_CMD 8'h01
`define MSI_ADDR_STAT 8'h02
`define MSI_ADDR_SPEED 8'h03
`define MSI_ADDR_WIDTH 8

// ****************************************
// Configuration register fields
// ****************************************
`define MSI_CFG_RD_SEL 0
`define MSI_CFG_FLAG 1
`define MSI_CFG_INV 2
`define MSI_CFG_SRC_LO 3
`define MSI_CFG_SRC_HI 4
`define MSI_CFG_MUL_LO 5
`define MSI_CFG_MUL_HI 6
`define MSI_CFG_DIV_LO 7
`define MSI_CFG_DIV_HI 8
`define MSI_CFG_SLEEP 9
`define MSI_CFG_ADDR_LO 10
`define MSI_CFG_ADDR_HI 16
`define MSI_CFG_RESET 17'h00000

// ****************************************
// Speed sources and control states
// ****************************************
`define MSI_SRC_PWM 2'h0
`define MSI_SRC_ANALOG 2'h1
`define MSI_SRC_SERIAL 2'h2
`define MSI_CTL_IDLE 2'h0
`define MSI_CTL_OPEN 2'h1
`define MSI_CTL_CLOSED 2'h2
`define MSI_CTL_FAULT 2'h3

// ****************************************
// Divider denominators
// ****************************************
`define MSI_DEN_1 3'h1
`define MSI_DEN_3 3'h3
`define MSI_DEN_4 3'h4
`define MSI_DEN_5 3'h5

// ****************************************
// Serial bus limit and clock
// ****************************************
`define MSI_SCL_MAX_KHZ 400
`define MSI_CLK_MHZ 100
`define MSI_SCL_MIN_CYC ((`MSI_CLK_MHZ * 1000) / `MSI_SCL_MAX_KHZ)

`endif

// ### logic/msi_pulse_gen.v
// Fractional tachometer pulse generator.
// Assumes one-cycle electrical-cycle event pulses in the clk domain.
`timescale 1ns/10ps
`default_nettype none
`include "msi_regs.vh"

module msi_pulse_gen (
    input wire clk,
    input wire nrst,
    input wire elec_evt,
    input wire [2:0] mul_k,
    input wire [2:0] den_k,
    output reg pulse_ff
);

    // ****************************************
    // Accumulator
    // ****************************************
    // Adds mul per event and takes den per output pulse, so remainders
    // carry over and no drift builds up; several pulses may be pending.
    reg [3:0] acc_ff; // Fraction accumulator
    reg [3:0] nxt_acc;
    reg nxt_pulse;
    reg [4:0] sum;

    // Next state: a pulse whenever a whole den is pending, never two in a row
    always @* begin
        sum = {1'b0, acc_ff} + (elec_evt ? {2'b00, mul_k} : 5'h00);
        nxt_pulse = (acc_ff >= {1'b0, den_k}) && !pulse_ff;
        if (nxt_pulse) begin
            nxt_acc = sum[3:0] - {1'b0, den_k};
        end else begin
            nxt_acc = sum[3:0];
        end
    end

    // State registers
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            acc_ff <= 4'h0;
            pulse_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            pulse_ff <= nxt_pulse;
        end
    end

endmodule // msi_pulse_gen
`default_nettype wire

// ### logic/msi_cmd_select.v
// Speed command source select with optional inversion.
// Assumes duty words already measured from the PWM and analog inputs.
`timescale 1ns/10ps
`default_nettype none
`include "msi_regs.vh"

module msi_cmd_select #(
    parameter W = 8
) (
    input wire clk,
    input wire nrst,
    input wire [1:0] src,
    input wire invert,
    input wire [W-1:0] pwm_duty,
    input wire [W-1:0] analog_duty,
    input wire [W-1:0] serial_cmd,
    output reg [W-1:0] cmd_ff
);

    reg [W-1:0] nxt_cmd;

    // ****************************************
    // Source mux
    // ****************************************
    // Only one source feeds the command; serial ignores the pin inputs
    always @* begin
        if (src == `MSI_SRC_PWM) begin
            nxt_cmd = invert ? ~pwm_duty : pwm_duty;
        end else if (src == `MSI_SRC_ANALOG) begin
            nxt_cmd = invert ? ~analog_duty : analog_duty;
        end else if (src == `MSI_SRC_SERIAL) begin
            nxt_cmd = serial_cmd;
        end else begin
            nxt_cmd = {W{1'b0}}; // Unused code: motor stays commanded off
        end
    end

    // Registered command
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmd_ff <= {W{1'b0}};
        end else begin
            cmd_ff <= nxt_cmd;
        end
    end

endmodule // msi_cmd_select
`default_nettype wire

// ### dv/msi_checker.sv
// Port assertions for msi_top.
// Assumes bind onto msi_top; config shadowed from bus writes.
`timescale 1ns/10ps
`default_nettype none
`include "msi_regs.vh"
module msi_checker #(
    parameter W = 8
) (
    input wire clk,
    input wire nrst,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire elec_evt,
    input wire [1:0] ctl_state,
    input wire dir_in,
    input wire [W-1:0] pwm_duty,
    input wire [W-1:0] analog_duty,
    input wire [6:0] serial_addr_in,
    input wire serial_addr_valid,
    input wire serial_addr_match,
    input wire indicator_pin_oe,
    input wire tacho_pulse_out,
    input wire [2:0] phase_order_ff,
    input wire [W-1:0] speed_cmd,
    input wire sleep_ff
);
    // ***
    // Shadows
    // ***
    reg [16:0] cfg_ff; // Config as last written
    reg [W-1:0] scmd_ff; // Serial command as last written
    wire [W-1:0] in_sel = (cfg_ff[4:3] == `MSI_SRC_ANALOG) ? analog_duty : pwm_duty;
    wire [W-1:0] exp_cmd = cfg_ff[4] ? scmd_ff : in_sel ^ {W{cfg_ff[2]}};
    wire run = cfg_ff[1] ? (ctl_state == `MSI_CTL_CLOSED) : (ctl_state[0] ^ ctl_state[1]);
    wire [2:0] ph_fwd = {phase_order_ff[1:0], phase_order_ff[2]}; // U then V then W
    wire [2:0] ph_rev = {phase_order_ff[0], phase_order_ff[2:1]}; // U then W then V
    wire [2:0] exp_ph = dir_in ? ph_fwd : ph_rev;
    reg [5:0] slp_cnt_ff; // Cycles asleep, saturating; pending pulses drain first
    always @(posedge clk or negedge nrst) begin
        if (!nrst) slp_cnt_ff <= 6'h00;
        else if (!sleep_ff) slp_cnt_ff <= 6'h00;
        else if (slp_cnt_ff != 6'h20) slp_cnt_ff <= slp_cnt_ff + 6'h01;
    end
    // Follows the same strobes as the block, so both agree at each edge
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_ff <= `MSI_CFG_RESET;
            scmd_ff <= {W{1'h0}};
        end else if (reg_wr && reg_addr == `MSI_ADDR_CFG) begin
            cfg_ff <= reg_wdata[16:0];
        end else if (reg_wr && reg_addr == `MSI_ADDR_CMD) begin
            scmd_ff <= reg_wdata[W-1:0];
        end
    end
    // ***
    // Properties
    // ***
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_asleep; sleep_ff [*6]; endsequence
    sequence s_step; elec_evt && !sleep_ff; endsequence
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read cycle");
    a_status_read: assert property ((reg_rd && reg_addr == `MSI_ADDR_STAT) |=>
        reg_rdata[3:0] == {$past(sleep_ff), $past(ctl_state), $past(tacho_pulse_out)})
        else $error("status word wrong");
    a_run_status: assert property (cfg_ff[0] |=> indicator_pin_oe == $past(run))
        else $error("run status level wrong");
    a_tacho_closed: assert property ((!cfg_ff[0] && ctl_state == `MSI_CTL_CLOSED)
        |=> indicator_pin_oe == !$past(tacho_pulse_out)) else $error("pin not tracking tacho");
    a_addr_match: assert property (serial_addr_match ==
        (serial_addr_valid && serial_addr_in == cfg_ff[16:10])) else $error("address match wrong");
    a_sleep_track: assert property ((reg_wr && reg_addr == `MSI_ADDR_CFG)
        |-> ##2 sleep_ff == $past(reg_wdata[9], 2)) else $error("sleep state wrong");
    a_sleep_quiet: assert property ((slp_cnt_ff == 6'h20) |-> !tacho_pulse_out)
        else $error("pulse while asleep");
    a_cmd_select: assert property (cfg_ff[4:3] != 2'h3 |=> speed_cmd == $past(exp_cmd))
        else $error("speed command wrong");
    a_phase_step: assert property (s_step |=> phase_order_ff == $past(exp_ph))
        else $error("phase order wrong");
    a_pulse_cause: assert property ((tacho_pulse_out && cfg_ff[8:5] == 4'h0) |->
        ($past(elec_evt, 2) || $past(tacho_pulse_out, 2))) else $error("pulse without event");
endmodule // msi_checker
bind msi_top msi_checker #(.W(W)) msi_checker_inst (.clk(clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .elec_evt(elec_evt), .ctl_state(ctl_state), .dir_in(dir_in),
    .pwm_duty(pwm_duty), .analog_duty(analog_duty), .serial_addr_in(serial_addr_in),
    .serial_addr_valid(serial_addr_valid), .serial_addr_match(serial_addr_match),
    .indicator_pin_oe(indicator_pin_oe), .tacho_pulse_out(tacho_pulse_out),
    .phase_order_ff(phase_order_ff), .speed_cmd(speed_cmd), .sleep_ff(sleep_ff));
`default_nettype wire

// ### dv/msi_host_model.sv
// Host side of the indicator pin: pull-up and tacho pulse counter.
// Assumes one-cycle tacho pulses in the clk domain.
`timescale 1ns/10ps
`default_nettype none
module msi_host_model (
    input wire logic clk,
    input wire logic pin_o,
    input wire logic pin_oe,
    input wire logic pulse,
    input wire logic clr,
    output wire logic pin_level,
    output var logic [15:0] pulse_cnt
);
    // Pull-up wins whenever the device lets go of the pin
    assign pin_level = pin_oe ? pin_o : 1'h1;
    // Counts pulse cycles as a host tacho input would
    always @(posedge clk) begin
        if (clr) pulse_cnt <= 16'h0000;
        else if (pulse) pulse_cnt <= pulse_cnt + 16'h0001;
    end
endmodule // msi_host_model
`default_nettype wire

// ### dv/msi_top_tb.sv
// Self-checking bench for msi_top.
// Assumes the design header on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "msi_regs.vh"
module msi_top_tb;
    logic clk, nrst, reg_wr, reg_rd, elec_evt, dir_in, sa_valid, clr;
    logic [7:0] reg_addr, pwm_duty, analog_duty, p;
    logic [31:0] reg_wdata, d;
    logic [1:0] ctl_state;
    logic [6:0] sa;
    wire [31:0] reg_rdata;
    wire match, pin_o, pin_oe, pulse, sleep, pin;
    wire [2:0] phase;
    wire [7:0] cmd;
    wire [15:0] cnt;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    int den[4] = '{1, 3, 4, 5}; // Denominator per divide code
    msi_top #(.W(8)) msi_top_inst (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .elec_evt(elec_evt), .ctl_state(ctl_state), .dir_in(dir_in), .pwm_duty(pwm_duty),
        .analog_duty(analog_duty), .serial_addr_in(sa), .serial_addr_valid(sa_valid),
        .serial_addr_match(match), .indicator_pin_o(pin_o), .indicator_pin_oe(pin_oe),
        .tacho_pulse_out(pulse), .phase_order_ff(phase), .speed_cmd(cmd), .sleep_ff(sleep));
    msi_host_model msi_host_model_inst (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe),
        .pulse(pulse), .clr(clr), .pin_level(pin), .pulse_cnt(cnt));
    // ***
    // Tasks
    // ***
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask
    // Gap cycle after each write keeps strobes from being driven twice at one edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 v = reg_rdata;
        @(posedge clk);
    endtask
    // Events spaced so that four pulses per event still fit
    task automatic evts(input int n);
        repeat (n) begin
            elec_evt <= 1'h1;
            @(posedge clk);
            elec_evt <= 1'h0;
            repeat (7) @(posedge clk);
        end
    endtask
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    // Hang guard, about two and a half times the expected run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end
    // ***
    // Main sequence
    // ***
    initial begin
        {nrst, reg_wr, reg_rd, elec_evt, dir_in, sa_valid, clr} = 7'h00;
        {reg_addr, reg_wdata, pwm_duty, analog_duty, sa} = 63'h0;
        ctl_state = `MSI_CTL_CLOSED;
        repeat (20) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
        rd(`MSI_ADDR_CFG, d);
        chk(d, 32'h0, "config reset");
        wr(`MSI_ADDR_CFG, 32'hFFFFFFFF);
        rd(`MSI_ADDR_CFG, d);
        chk(d, 32'h0001FFFF, "config mask");
        chk(sleep, 32'h1, "sleep set");
        rd(`MSI_ADDR_STAT, d);
        chk(d & 32'hF, 32'hC, "status word");
        rd(8'h10, d);
        chk(d, 32'h0, "unmapped read");
        $display("registers done");
        // Every multiply and divide code; 60 events is whole for each divisor
        for (int m = 0; m < 4; m++) for (int v = 0; v < 4; v++) begin
            wr(`MSI_ADDR_CFG, {23'h0, v[1:0], m[1:0], 5'h00});
            dir_in <= m[0];
            clr <= 1'h1;
            @(posedge clk);
            clr <= 1'h0;
            evts(60);
            repeat (2) @(posedge clk);
            chk(cnt, 32'(60 * (m + 1) / den[v]), "pulse count");
        end
        $display("tacho done");
        for (int f = 0; f < 2; f++) for (int s = 0; s < 4; s++) begin
            wr(`MSI_ADDR_CFG, 32'h1 | (f << 1));
            ctl_state <= s[1:0];
            repeat (3) @(posedge clk);
            chk(pin, (s == 2 || (f == 0 && s == 1)) ? 0 : 1, "run status");
        end
        ctl_state <= `MSI_CTL_CLOSED;
        $display("status done");
        wr(`MSI_ADDR_CMD, 32'h5A);
        for (int s = 0; s < 3; s++) for (int i = 0; i < 2; i++) begin
            p = 8'h31 + 8'(s * 16 + i);
            pwm_duty <= p;
            analog_duty <= ~p + 8'h07;
            wr(`MSI_ADDR_CFG, (s << 3) | (i << 2));
            if (s == 1) p = ~p + 8'h07;
            @(posedge clk);
            chk(cmd, (s == 2) ? 8'h5A : p ^ {8{i[0]}}, "speed cmd");
        end
        $display("command done");
        wr(`MSI_ADDR_CFG, 32'h200);
        clr <= 1'h1;
        @(posedge clk);
        clr <= 1'h0;
        evts(5);
        chk(cnt, 32'h0, "pulses in sleep");
        for (int j = 0; j < 2; j++) begin
            wr(`MSI_ADDR_CFG, {15'h0, (j ? 7'h5A : 7'h00), 10'h000});
            sa <= j ? 7'h5A : 7'h00;
            sa_valid <= 1'h1;
            #1 chk(match, 32'h1, "address hit");
            @(posedge clk);
            sa <= sa ^ 7'h01;
            #1 chk(match, 32'h0, "address miss");
            @(posedge clk);
        end
        $display("sleep and address done");
        wrap_up();
    end
endmodule // msi_top_tb
`default_nettype wire
